// ==== design/acrb_device.sv ====
// Our own choice: the serial register port.
`timescale 1ns/1ps
`include "acrb_defs.svh"
module acrb_device (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    acrb_if.device                      port,
    input  wire logic                   extended_control_pin,
    input  wire logic                   sample_clk_en,
    input  wire logic                   clock_reset_in,
    output logic                        output_phase_select,
    output logic                        output_swing_select,
    output logic                        test_pattern_enable,
    output logic                        i_channel_powerdown,
    output logic                        q_channel_powerdown,
    output logic                        low_clock_rate_select,
    output logic                        interleave_q_input,
    output logic                        interleave_dual_input,
    output logic                        output_coding_select,
    output logic                        time_stamp_enable,
    output logic                        resistor_trim_skip,
    output logic                        serial_cal_control,
    output logic                        i_offset_sign,
    output logic [`ACRB_OMAG_W-1:0]     i_offset_mag,
    output logic                        q_offset_sign,
    output logic [`ACRB_OMAG_W-1:0]     q_offset_mag,
    output logic [`ACRB_DATA_W-1:0]     i_full_scale_mv,
    output logic [`ACRB_DATA_W-1:0]     q_full_scale_mv,
    output logic [`ACRB_DATA_W-1:0]     cal_prerequisite,
    output logic                        duty_cycle_correct_en,
    output logic                        coarse_aperture_adjust_en,
    output logic                        fine_aperture_adjust_en,
    output logic [`ACRB_CRS_W-1:0]      coarse_delay_applied,
    output logic [`ACRB_FIN_W-1:0]      fine_delay_applied,
    output logic                        clock_reset_disable,
    output logic                        clock_reset_taken,
    output logic                        ref_clock_output_disable,
    output logic                        ref_clock_output_one,
    output logic                        ref_clock_output_two,
    output logic                        sync_slave_enable,
    output logic [1:0]                  sync_phase_select,
    output logic [`ACRB_DLY_W-1:0]      ref_delay_code
);
    logic [`ACRB_DATA_W-1:0] cfg_ff, cal_ff, io_ff, ifs_ff, qo_ff;
    logic [`ACRB_DATA_W-1:0] qfs_ff, pre_ff, adj_ff, sync_ff;
    logic [2:0] sclk_sync_ff, cs_sync_ff;
    logic [1:0] sdi_sync_ff;
    logic [4:0] bit_cnt_ff;
    logic [20:0] shift_ff;
    logic [`ACRB_DATA_W-1:0] rd_ff;
    logic sdo_oe_ff;
    logic [1:0] quarter_ff;
    logic sclk_rise, sclk_fall, cs_act, cs_end, wr_go, serial_ok;
    logic [`ACRB_ADDR_W-1:0] waddr, raddr;
    logic [`ACRB_DATA_W-1:0] wdata, rd_sel;
    logic [`ACRB_DLY_W-1:0] dly_raw;

    // Two-stage sync; only stage 2 and later are examined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff   <= 3'h7;
            sdi_sync_ff  <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], port.sclk};
            cs_sync_ff   <= {cs_sync_ff[1:0], port.scs_n};
            sdi_sync_ff  <= {sdi_sync_ff[0], port.sdi};
        end
    end
    assign serial_ok = !extended_control_pin; // RL23
    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    assign cs_act    = ~cs_sync_ff[1];
    assign cs_end    = cs_sync_ff[1] & ~cs_sync_ff[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_ff <= 5'h00;
            shift_ff   <= 21'h000000;
        end else if (!cs_act) begin
            bit_cnt_ff <= 5'h00;
        end else if (sclk_rise && bit_cnt_ff != `ACRB_FRAME_LEN) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            shift_ff   <= {shift_ff[19:0], sdi_sync_ff[1]};
        end
    end

    // Partial frames are dropped at chip-select end
    assign wr_go = cs_end && bit_cnt_ff == `ACRB_FRAME_LEN
                   && !shift_ff[20] && serial_ok; // RL24
    assign waddr = shift_ff[19:16];
    assign wdata = shift_ff[15:0];
    assign raddr = shift_ff[3:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff  <= `ACRB_R_CONFIG;
            cal_ff  <= `ACRB_R_CAL;
            io_ff   <= `ACRB_R_OFFS;
            ifs_ff  <= `ACRB_R_FS;
            qo_ff   <= `ACRB_R_OFFS;
            qfs_ff  <= `ACRB_R_FS;
            pre_ff  <= `ACRB_R_CALPRE;
            adj_ff  <= `ACRB_R_ADJ;
            sync_ff <= `ACRB_R_SYNC;
        end else if (wr_go) begin // RL24
            if (waddr == `ACRB_A_CONFIG) begin
                cfg_ff <= wdata;
            end else if (waddr == `ACRB_A_CAL) begin
                cal_ff <= wdata;
            end else if (waddr == `ACRB_A_I_OFFS) begin
                io_ff <= wdata; // RL12
            end else if (waddr == `ACRB_A_I_FS) begin
                ifs_ff <= (wdata < `ACRB_FS_MIN) ? `ACRB_FS_MIN :
                          (wdata > `ACRB_FS_MAX) ? `ACRB_FS_MAX : wdata; // RL13
            end else if (waddr == `ACRB_A_Q_OFFS) begin
                qo_ff <= wdata; // RL12
            end else if (waddr == `ACRB_A_Q_FS) begin
                qfs_ff <= (wdata < `ACRB_FS_MIN) ? `ACRB_FS_MIN :
                          (wdata > `ACRB_FS_MAX) ? `ACRB_FS_MAX : wdata; // RL13
            end else if (waddr == `ACRB_A_CALPRE) begin
                pre_ff <= wdata;
            end else if (waddr == `ACRB_A_ADJ) begin
                adj_ff <= wdata;
            end else if (waddr == `ACRB_A_SYNC) begin
                sync_ff <= wdata;
            end
        end
    end

    // Read back, shifted out on sclk falling edges
    always_comb begin
        rd_sel = 16'h0000;
        if (raddr == `ACRB_A_CONFIG) begin
            rd_sel = cfg_ff;
        end else if (raddr == `ACRB_A_CAL) begin
            rd_sel = cal_ff;
        end else if (raddr == `ACRB_A_I_OFFS) begin
            rd_sel = io_ff;
        end else if (raddr == `ACRB_A_I_FS) begin
            rd_sel = ifs_ff;
        end else if (raddr == `ACRB_A_Q_OFFS) begin
            rd_sel = qo_ff;
        end else if (raddr == `ACRB_A_Q_FS) begin
            rd_sel = qfs_ff;
        end else if (raddr == `ACRB_A_CALPRE) begin
            rd_sel = pre_ff;
        end else if (raddr == `ACRB_A_ADJ) begin
            rd_sel = adj_ff;
        end else if (raddr == `ACRB_A_SYNC) begin
            rd_sel = sync_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff     <= 16'h0000;
            sdo_oe_ff <= 1'b0;
        end else if (!cs_act) begin
            sdo_oe_ff <= 1'b0;
        end else if (sclk_fall && bit_cnt_ff == 5'd5 && shift_ff[4]) begin
            rd_ff     <= rd_sel;
            sdo_oe_ff <= serial_ok;
        end else if (sclk_fall && sdo_oe_ff) begin
            rd_ff <= {rd_ff[14:0], 1'b0};
        end
    end
    assign port.sdo    = rd_ff[15];
    assign port.sdo_oe = sdo_oe_ff;

    // Config word decoded straight to controls
    assign output_phase_select   = cfg_ff[`ACRB_B_PHASE]; // RL1
    assign output_swing_select   = cfg_ff[`ACRB_B_SWING]; // RL2
    assign test_pattern_enable   = cfg_ff[`ACRB_B_TPAT]; // RL3
    assign i_channel_powerdown   = cfg_ff[`ACRB_B_PDI]; // RL4
    assign q_channel_powerdown   = cfg_ff[`ACRB_B_PDQ]; // RL4
    assign low_clock_rate_select = cfg_ff[`ACRB_B_LFS]; // RL5
    assign interleave_q_input    = cfg_ff[`ACRB_B_INTERLEAVE_Q_INPUT]; // RL6
    assign interleave_dual_input = cfg_ff[`ACRB_B_INTERLEAVE_DUAL_INPUT]; // RL7
    assign output_coding_select  = cfg_ff[`ACRB_B_CODE]; // RL8
    assign time_stamp_enable     = cfg_ff[`ACRB_B_TSE]; // RL9
    assign resistor_trim_skip    = cal_ff[`ACRB_B_TRIM]; // RL10
    assign serial_cal_control    = cal_ff[`ACRB_B_SSC]; // RL11
    assign i_offset_sign = io_ff[`ACRB_B_OSIGN]; // RL12
    assign i_offset_mag  = io_ff[`ACRB_OMAG_W-1:0]; // RL12
    assign q_offset_sign = qo_ff[`ACRB_B_OSIGN];
    assign q_offset_mag  = qo_ff[`ACRB_OMAG_W-1:0];
    assign i_full_scale_mv  = ifs_ff;
    assign q_full_scale_mv  = qfs_ff;
    assign cal_prerequisite = pre_ff;
    assign duty_cycle_correct_en     = adj_ff[`ACRB_B_DCC]; // RL15
    assign coarse_aperture_adjust_en = adj_ff[`ACRB_B_CEN];
    assign fine_aperture_adjust_en   = adj_ff[`ACRB_B_FEN];
    // Fine wins over coarse
    assign coarse_delay_applied = (adj_ff[`ACRB_B_CEN] && !adj_ff[`ACRB_B_FEN])
        ? adj_ff[`ACRB_CRS_W+`ACRB_FIN_W-1:`ACRB_FIN_W]
        : 5'h00; // RL16 RL17
    assign fine_delay_applied = adj_ff[`ACRB_B_FEN]
        ? adj_ff[`ACRB_FIN_W-1:0] : 8'h00; // RL17
    assign clock_reset_disable = sync_ff[`ACRB_B_DR];
    assign clock_reset_taken = clock_reset_in && !sync_ff[`ACRB_B_DR]; // RL18
    assign ref_clock_output_disable = sync_ff[`ACRB_B_DOC];
    assign sync_slave_enable = sync_ff[`ACRB_B_ES]; // RL20
    assign sync_phase_select = sync_ff[`ACRB_B_ES]
        ? sync_ff[`ACRB_PH_HI:`ACRB_PH_LO] : 2'h0; // RL20
    assign dly_raw = sync_ff[`ACRB_DLY_W-1:0];
    assign ref_delay_code = (dly_raw > `ACRB_DLY_MAX)
        ? `ACRB_DLY_MAX : dly_raw; // RL21

    // Quarter-rate reference clock from sample clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quarter_ff <= 2'h0;
        end else if (sample_clk_en) begin
            quarter_ff <= quarter_ff + 2'h1;
        end
    end
    assign ref_clock_output_one = !sync_ff[`ACRB_B_DOC] & quarter_ff[1]; // RL19
    assign ref_clock_output_two = !sync_ff[`ACRB_B_DOC] & quarter_ff[1]; // RL19
endmodule

// ==== include/acrb_defs.svh ====
`ifndef ACRB_DEFS_SVH
`define ACRB_DEFS_SVH
// Summary of operation
// RL1: Phase select bit picks 0 or 90 degrees
// RL2: Swing bit picks reduced or standard amplitude
// RL3: Test pattern bit replaces conversion data output
// RL4: I and Q power-down bits act independently
// RL5: Low clock rate bit, host sets below 300MHz
// RL6: Interleave Q-input bit selects Q input
// RL7: Interleave dual-input bit ties I and Q
// RL8: Coding bit: set two's complement, clear offset binary
// RL9: Time stamp bit enables time stamp
// RL10: Trim skip bit skips resistor trim step
// RL11: Serial cal bit takes commands from port
// RL12: Per channel offset sign and magnitude held
// RL13: Full-scale 600 to 1000mV, default 800mV
// RL14: Host recalibrates after full-scale change
// RL15: Duty cycle correction on, set by default
// RL16: Coarse enable applies coarse aperture delay
// RL17: Fine enable applies fine, overrides coarse
// RL18: Clock reset input ignored, default disabled
// RL19: Ref clock outputs quarter rate when enabled
// RL20: Slave bit uses selected reference phase
// RL21: Reference delay code clamps above 319
// RL22: Host writes 1C00h to address 6 first
// RL23: Host uses serial control only, pin low
// RL24: Settings apply only after complete write

// Serial frame: 1 read bit, 4 address bits, 16 data bits
`define ACRB_ADDR_W      4
`define ACRB_DATA_W      16
`define ACRB_FRAME_LEN   5'd21
`define ACRB_SCLK_DIV    4'd4

// Device register addresses
`define ACRB_A_CONFIG    4'h0
`define ACRB_A_CAL       4'h1
`define ACRB_A_I_OFFS    4'h2
`define ACRB_A_I_FS      4'h3
`define ACRB_A_Q_OFFS    4'h4
`define ACRB_A_Q_FS      4'h5
`define ACRB_A_CALPRE    4'h6
`define ACRB_A_ADJ       4'h7
`define ACRB_A_SYNC      4'h8

// Config register bits
`define ACRB_B_PHASE     0
`define ACRB_B_SWING     1
`define ACRB_B_TPAT      2
`define ACRB_B_PDI       3
`define ACRB_B_PDQ       4
`define ACRB_B_LFS       5
`define ACRB_B_INTERLEAVE_Q_INPUT      6
`define ACRB_B_INTERLEAVE_DUAL_INPUT     7
`define ACRB_B_CODE      8
`define ACRB_B_TSE       9
// Cal register bits
`define ACRB_B_TRIM      0
`define ACRB_B_SSC       1
// Offset register: sign at 15, magnitude 11:0
`define ACRB_B_OSIGN     15
`define ACRB_OMAG_W      12
// Adjust register: dcc 15, coarse en 14, fine en 13
`define ACRB_B_DCC       15
`define ACRB_B_CEN       14
`define ACRB_B_FEN       13
`define ACRB_CRS_W       5
`define ACRB_FIN_W       8
// Sync register: dr 15, doc 14, es 13, phase 12:11, delay 8:0
`define ACRB_B_DR        15
`define ACRB_B_DOC       14
`define ACRB_B_ES        13
`define ACRB_PH_HI       12
`define ACRB_PH_LO       11
`define ACRB_DLY_W       9
`define ACRB_DLY_MAX     9'd319

// Full-scale code in mV
`define ACRB_FS_MIN      16'h0258
`define ACRB_FS_MAX      16'h03E8

// Reset values
`define ACRB_R_CONFIG    16'h0000
`define ACRB_R_CAL       16'h0000
`define ACRB_R_OFFS      16'h0000
`define ACRB_R_FS        16'h0320
`define ACRB_R_CALPRE    16'h0000
`define ACRB_R_ADJ       16'h8000
`define ACRB_R_SYNC      16'hC000
`define ACRB_CALPRE_VAL  16'h1C00

// Host APB registers
`define ACRB_P_CMD       12'h000
`define ACRB_P_WDATA     12'h004
`define ACRB_P_STATUS    12'h008
`define ACRB_P_RDATA     12'h00C
`define ACRB_CMD_GO      8
`define ACRB_CMD_RD      7
`endif

// ==== include/acrb_pkg.sv ====
package acrb_pkg;
    typedef enum logic [1:0] {
        ACRB_IDLE,
        ACRB_SHIFT,
        ACRB_DONE
    } acrb_host_state_type;
endpackage

// ==== include/acrb_if.sv ====
`timescale 1ns/1ps
interface acrb_if;
    logic sclk;
    logic scs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    modport device (
        input  sclk,
        input  scs_n,
        input  sdi,
        output sdo,
        output sdo_oe
    );
    modport host (
        output sclk,
        output scs_n,
        output sdi,
        input  sdo,
        input  sdo_oe
    );
endinterface

// ==== design/acrb_host.sv ====
`timescale 1ns/1ps
`include "acrb_defs.svh"
module acrb_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             extended_control_pin,
    acrb_if.host             port
);
    acrb_pkg::acrb_host_state_type state_ff;
    logic [`ACRB_ADDR_W-1:0] addr_ff;
    logic [`ACRB_DATA_W-1:0] wdata_ff, rdata_ff;
    logic rd_ff, done_ff, sclk_ff, en_ff;
    logic [20:0] sh_ff;
    logic [4:0] cnt_ff;
    logic [3:0] div_ff;
    logic [1:0] sdo_sync_ff;
    logic wr_acc, tick, go;

    assign wr_acc  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign go = wr_acc && paddr == `ACRB_P_CMD && pwdata[`ACRB_CMD_GO]
                && state_ff == acrb_pkg::ACRB_IDLE;
    // Serial control needs the pin held low
    assign extended_control_pin = 1'b0; // RL23

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff  <= 4'h0;
            rd_ff    <= 1'b0;
            wdata_ff <= 16'h0000;
        end else if (wr_acc && paddr == `ACRB_P_WDATA) begin
            wdata_ff <= pwdata[15:0];
        end else if (go) begin
            addr_ff <= pwdata[3:0];
            rd_ff   <= pwdata[`ACRB_CMD_RD];
        end
    end

    always_comb begin
        prdata = 32'h00000000;
        if (paddr == `ACRB_P_CMD) begin
            prdata = {27'h0, rd_ff, addr_ff};
        end else if (paddr == `ACRB_P_WDATA) begin
            prdata = {16'h0000, wdata_ff};
        end else if (paddr == `ACRB_P_STATUS) begin
            prdata = {30'h0, done_ff, state_ff != acrb_pkg::ACRB_IDLE};
        end else if (paddr == `ACRB_P_RDATA) begin
            prdata = {16'h0000, rdata_ff};
        end
    end

    // Serial clock half period from divider enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 4'h0;
        end else if (tick || state_ff != acrb_pkg::ACRB_SHIFT) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign tick = div_ff == `ACRB_SCLK_DIV - 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_sync_ff <= 2'h0;
        end else begin
            sdo_sync_ff <= {sdo_sync_ff[0], port.sdo};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= acrb_pkg::ACRB_IDLE;
            sh_ff    <= 21'h000000;
            cnt_ff   <= 5'h00;
            sclk_ff  <= 1'b0;
            en_ff    <= 1'b1;
            done_ff  <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            case (state_ff)
                acrb_pkg::ACRB_IDLE: begin
                    if (go) begin
                        sh_ff <= {pwdata[`ACRB_CMD_RD], pwdata[3:0], wdata_ff};
                        cnt_ff   <= 5'h00;
                        en_ff    <= 1'b0;
                        done_ff  <= 1'b0;
                        state_ff <= acrb_pkg::ACRB_SHIFT;
                    end
                end
                acrb_pkg::ACRB_SHIFT: begin
                    if (tick) begin
                        sclk_ff <= ~sclk_ff;
                        if (sclk_ff) begin
                            sh_ff  <= {sh_ff[19:0], 1'b0};
                            rdata_ff <= {rdata_ff[14:0], sdo_sync_ff[1]};
                            if (cnt_ff == `ACRB_FRAME_LEN - 5'h01) begin
                                state_ff <= acrb_pkg::ACRB_DONE;
                            end
                            cnt_ff <= cnt_ff + 5'h01;
                        end
                    end
                end
                acrb_pkg::ACRB_DONE: begin
                    // Chip select rises only after last bit
                    en_ff    <= 1'b1;
                    done_ff  <= 1'b1;
                    state_ff <= acrb_pkg::ACRB_IDLE;
                end
                default: begin
                    state_ff <= acrb_pkg::ACRB_IDLE;
                end
            endcase
        end
    end
    assign port.sclk  = sclk_ff;
    assign port.scs_n = en_ff;
    assign port.sdi   = sh_ff[20];
endmodule

// ==== verif/acrb_link_asserts.sv ====
`timescale 1ns/1ps
`include "acrb_defs.svh"
module acrb_link_asserts (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   sclk,
    input wire logic                   scs_n,
    input wire logic                   sdi,
    input wire logic                   sdo,
    input wire logic                   sdo_oe,
    input wire logic                   clock_reset_in,
    input wire logic                   clock_reset_disable,
    input wire logic                   clock_reset_taken,
    input wire logic                   ref_clock_output_disable,
    input wire logic                   ref_clock_output_one,
    input wire logic                   ref_clock_output_two,
    input wire logic                   fine_aperture_adjust_en,
    input wire logic [`ACRB_CRS_W-1:0] coarse_delay_applied,
    input wire logic [`ACRB_DLY_W-1:0] ref_delay_code
);
    logic       sclk_ff;
    logic [5:0] bits_ff;
    logic [5:0] nxt_bits;

    // Rising serial clocks seen in the current frame
    assign nxt_bits = scs_n ? 6'h00 : bits_ff + {5'h00, sclk & ~sclk_ff};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_ff <= 1'b0;
            bits_ff <= 6'h00;
        end else begin
            sclk_ff <= sclk;
            bits_ff <= nxt_bits;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IDLE_CLK: assert property (scs_n |-> !sclk)
        else $error("serial clock active outside a frame");
    AST_FRAME_LEN: assert property ($rose(scs_n) |-> bits_ff == 6'h15)
        else $error("frame closed with wrong bit count");
    AST_HALF_HI: assert property ($rose(sclk) |-> sclk [*4])
        else $error("serial clock high half too short");
    AST_HALF_LO: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low half too short");
    AST_OE_FRAME: assert property (sdo_oe |-> !$past(scs_n, 3))
        else $error("read data driven outside a frame");
    AST_REF_OFF: assert property (ref_clock_output_disable |->
        !(ref_clock_output_one || ref_clock_output_two))
        else $error("reference clock out while disabled");
    AST_REF_PAIR: assert property (ref_clock_output_one == ref_clock_output_two)
        else $error("reference clock outputs differ");
    AST_DR_GATE: assert property (clock_reset_taken ==
        (clock_reset_in && !clock_reset_disable))
        else $error("clock reset gating wrong");
    AST_FINE_WINS: assert property (fine_aperture_adjust_en |->
        coarse_delay_applied == '0)
        else $error("coarse delay applied under fine enable");
    AST_DLY_CLAMP: assert property (ref_delay_code <= `ACRB_DLY_MAX)
        else $error("reference delay above clamp");

    cover property ($rose(scs_n));
    cover property (sdo_oe);
    cover property ($rose(ref_clock_output_one));
endmodule

// ==== verif/tb_adc_control_register_bank.sv ====
`timescale 1ns/1ps
`include "acrb_defs.svh"
module tb_adc_control_register_bank;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        extended_control_pin, sample_clk_en, clock_reset_in;
    logic        output_phase_select, output_swing_select;
    logic        test_pattern_enable, i_channel_powerdown;
    logic        q_channel_powerdown, low_clock_rate_select;
    logic        interleave_q_input, interleave_dual_input;
    logic        output_coding_select, time_stamp_enable;
    logic        resistor_trim_skip, serial_cal_control;
    logic        i_offset_sign, q_offset_sign;
    logic [11:0] i_offset_mag, q_offset_mag;
    logic [15:0] i_full_scale_mv, q_full_scale_mv, cal_prerequisite, d;
    logic        duty_cycle_correct_en, coarse_aperture_adjust_en;
    logic        fine_aperture_adjust_en, clock_reset_disable;
    logic        clock_reset_taken, ref_clock_output_disable;
    logic        ref_clock_output_one, ref_clock_output_two;
    logic        sync_slave_enable;
    logic [4:0]  coarse_delay_applied;
    logic [7:0]  fine_delay_applied;
    logic [1:0]  sync_phase_select;
    logic [8:0]  ref_delay_code;
    logic [9:0]  cfg;
    int          n_fail, cmp_count, cyc, a, n;
    logic [15:0] rv [0:8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0320,
        16'h0000, 16'h0320, 16'h0000, 16'h8000, 16'hC000};
    logic [15:0] fs_in [0:3] = '{16'h0257, 16'h0258, 16'h03E8, 16'h03E9};
    logic [15:0] fs_ex [0:3] = '{16'h0258, 16'h0258, 16'h03E8, 16'h03E8};
    logic [15:0] dl_in [0:3] = '{16'h0140, 16'h013F, 16'h013E, 16'h0000};
    logic [8:0]  dl_ex [0:3] = '{9'h13F, 9'h13F, 9'h13E, 9'h000};

    acrb_if link ();
    acrb_host i_acrb_host (.port(link), .*);
    acrb_device i_acrb_device (.port(link), .*);
    acrb_link_asserts u_chk (.sclk(link.sclk), .scs_n(link.scs_n),
        .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .*);

    assign cfg = {time_stamp_enable, output_coding_select,
        interleave_dual_input, interleave_q_input, low_clock_rate_select,
        q_channel_powerdown, i_channel_powerdown, test_pattern_enable,
        output_swing_select, output_phase_select};

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    // Sample clock enable pulses every other cycle
    always @(posedge pclk) sample_clk_en <= ~sample_clk_en;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end

    task stop_test();
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    // Holds the request until pready is sampled high, giving up after 100 cycles
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
             output logic [31:0] rd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task go(input logic [3:0] ad, input logic [15:0] v, input logic rd);
        logic [31:0] t;
        apb(1'b1, `ACRB_P_WDATA, {16'h0000, v}, t);
        apb(1'b1, `ACRB_P_CMD, {23'h000000, 1'b1, rd, 3'h0, ad}, t);
    endtask

    // Register update lands a few cycles after the frame closes
    task wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, `ACRB_P_STATUS, 32'h0, r);
            k++;
        end while (r[0] !== 1'b0 && k < 300);
        chk("busy wait", k < 300, 1);
        repeat (4) @(posedge pclk);
    endtask

    task dwr(input logic [3:0] ad, input logic [15:0] v);
        go(ad, v, 1'b0);
        wait_idle();
    endtask

    task drd(input logic [3:0] ad, output logic [15:0] v);
        go(ad, 16'h0000, 1'b1);
        wait_idle();
        apb(1'b0, `ACRB_P_RDATA, 32'h0, r);
        v = r[15:0];
    endtask

    task ref_toggles(output int t);
        logic p;
        t = 0;
        p = ref_clock_output_one;
        repeat (64) begin
            @(posedge pclk);
            if (ref_clock_output_one !== p) t++;
            p = ref_clock_output_one;
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, sample_clk_en} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        clock_reset_in = 1'b1;
        {n_fail, cmp_count, cyc} = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (a = 0; a < 9; a++) begin
            drd(a[3:0], d);
            chk("reset value", d, rv[a]);
        end
        chk("clock reset taken", clock_reset_taken, 0);
        ref_toggles(n);
        chk("ref clock idle", n, 0);
        for (a = 0; a < 10; a++) begin
            go(`ACRB_A_CONFIG, 16'h0001 << a, 1'b0);
            repeat (40) @(posedge pclk);
            chk("config mid frame", cfg, a == 0 ? 0 : 1 << (a - 1));
            wait_idle();
            chk("config bit", cfg, 1 << a);
        end
        dwr(`ACRB_A_CAL, 16'h0003);
        chk("cal bits", {resistor_trim_skip, serial_cal_control}, 3);
        dwr(`ACRB_A_CAL, 16'h0002);
        chk("cal bits", {resistor_trim_skip, serial_cal_control}, 1);
        dwr(`ACRB_A_I_OFFS, 16'h8FFF);
        dwr(`ACRB_A_Q_OFFS, 16'h0123);
        chk("i offset", {i_offset_sign, i_offset_mag}, 32'h1FFF);
        chk("q offset", {q_offset_sign, q_offset_mag}, 32'h0123);
        for (a = 0; a < 4; a++) begin
            dwr(`ACRB_A_I_FS, fs_in[a]);
            dwr(`ACRB_A_Q_FS, fs_in[3 - a]);
            chk("i full scale", i_full_scale_mv, fs_ex[a]);
            chk("q full scale", q_full_scale_mv, fs_ex[3 - a]);
        end
        dwr(`ACRB_A_CALPRE, 16'h1C00);
        dwr(`ACRB_A_CAL, 16'h0002);
        drd(`ACRB_A_CALPRE, d);
        chk("cal prerequisite", d, 32'h1C00);
        chk("cal prerequisite out", cal_prerequisite, 32'h1C00);
        dwr(`ACRB_A_ADJ, 16'h5FFF);
        chk("adjust enables", {duty_cycle_correct_en, coarse_aperture_adjust_en,
            fine_aperture_adjust_en}, 2);
        chk("coarse applied", coarse_delay_applied, 32'h1F);
        dwr(`ACRB_A_ADJ, 16'hFFFF);
        chk("coarse overridden", coarse_delay_applied, 0);
        chk("fine applied", fine_delay_applied, 32'hFF);
        dwr(`ACRB_A_SYNC, 16'h31FF);
        chk("slave", {sync_slave_enable, sync_phase_select}, 6);
        chk("clock reset taken", clock_reset_taken, 1);
        chk("delay clamp", ref_delay_code, 32'h13F);
        ref_toggles(n);
        chk("ref clock quarter rate", n >= 15 && n <= 17, 1);
        for (a = 0; a < 4; a++) begin
            dwr(`ACRB_A_SYNC, dl_in[a]);
            chk("delay code", ref_delay_code, dl_ex[a]);
        end
        apb(1'b0, 12'h010, 32'h0, r);
        chk("unmapped read", r, 0);
        stop_test();
    end
endmodule
